// *** verilog/ccs_pkg.sv ***
// ccs_pkg: constants, register map and carrier types for the core sfr bank.
// assumes a single 100 MHz clock domain and the direct sfr address bus.
package ccs_pkg;

	localparam logic [7:0] ADDR_PORT0     = 8'h80;
	localparam logic [7:0] ADDR_SP        = 8'h81;
	localparam logic [7:0] ADDR_DP0_LOW   = 8'h82;
	localparam logic [7:0] ADDR_DP0_HIGH  = 8'h83;
	localparam logic [7:0] ADDR_DP1_LOW   = 8'h84;
	localparam logic [7:0] ADDR_DP1_HIGH  = 8'h85;
	localparam logic [7:0] ADDR_STRETCH   = 8'h8e;
	localparam logic [7:0] ADDR_PORT1     = 8'h90;
	localparam logic [7:0] ADDR_PORT2     = 8'ha0;
	localparam logic [7:0] ADDR_PORT3     = 8'hb0;
	localparam logic [7:0] ADDR_PSW       = 8'hd0;
	localparam logic [7:0] ADDR_ACC       = 8'he0;
	localparam logic [7:0] ADDR_HELPER    = 8'hf0;

	localparam logic [15:0] IORAM_PORT_EN_ADDR = 16'h270c;
	localparam int          PORT_EN_BIT        = 5;

	localparam logic [7:0]  RST_PORT    = 8'hff;
	localparam logic [7:0]  RST_SP      = 8'h07;
	localparam logic [7:0]  RST_STRETCH = 8'h01;
	localparam logic [7:0]  RST_GEN     = 8'h00;
	localparam logic [15:0] RST_PC      = 16'h0000;

	localparam int PSW_CARRY   = 7;
	localparam int PSW_AUX     = 6;
	localparam int PSW_USER0   = 5;
	localparam int PSW_BANK_HI = 4;
	localparam int PSW_BANK_LO = 3;
	localparam int PSW_OVER    = 2;
	localparam int PSW_USER1   = 1;
	localparam int PSW_PARITY  = 0;

	localparam int STRETCH_W   = 3;
	localparam int XCNT_W      = 4;
	localparam logic [XCNT_W-1:0] READ_EXTRA  = 4'h1;
	localparam logic [XCNT_W-1:0] WRITE_EXTRA = 4'h2;

	localparam int NUM_PORTS = 4;
	localparam int NUM_PINS  = 16;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} ccs_sfr_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic [7:0]  wdata;
	} ccs_ioram_req_t;

	typedef struct packed {
		logic        acc_we;
		logic [7:0]  acc_wdata;
		logic        helper_we;
		logic [7:0]  helper_wdata;
		logic        flags_we;
		logic        carry;
		logic        aux;
		logic        over;
		logic        push;
		logic        pop;
		logic        pc_inc;
		logic        pc_load;
		logic [15:0] pc_wdata;
	} ccs_core_req_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ccs_xmem_req_t;

endpackage

// *** verilog/ccs_stretch_timer.sv ***
// ccs_stretch_timer: shapes extended-memory address and strobe widths.
// assumes start pulses from the same clock and a synchronised reset.
`timescale 1ns/10ps
`default_nettype none
module ccs_stretch_timer
(
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          start_rd,
	input  wire logic                          start_wr,
	input  wire logic [ccs_pkg::STRETCH_W-1:0] stretch,
	output logic                               addr_act,
	output logic                               rd_stb,
	output logic                               wr_stb,
	output logic                               busy
);
	import ccs_pkg::*;

	logic                 busy_r;
	logic                 is_wr_r;
	logic [STRETCH_W-1:0] stretch_r;
	logic [XCNT_W-1:0]    cnt_r;
	logic                 addr_act_r;
	logic                 rd_stb_r;
	logic                 wr_stb_r;

	wire                  start     = !busy_r && (start_rd || start_wr);
	wire                  wr_nxt    = start ? start_wr : is_wr_r;
	wire [STRETCH_W-1:0]  n_nxt     = start ? stretch : stretch_r;
	wire [XCNT_W-1:0]     n_ext     = {1'b0, n_nxt};
	// address lasts n+1 on read, n+2 on write
	wire [XCNT_W-1:0]     alen      = n_ext + (wr_nxt ? WRITE_EXTRA : READ_EXTRA);
	// write strobe never shorter than one cycle
	wire [XCNT_W-1:0]     wlen      = (n_ext == 4'h0) ? 4'h1 : n_ext;
	wire                  last      = (cnt_r + 4'h1) >= alen;
	wire                  busy_nxt  = start || (busy_r && !last);
	wire [XCNT_W-1:0]     cnt_nxt   = start ? 4'h0 : (cnt_r + 4'h1);
	// strobe starts one cycle after the address for setup margin
	wire                  wr_win    = (cnt_nxt >= 4'h1) && (cnt_nxt <= wlen);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_r     <= 1'b0;
			is_wr_r    <= 1'b0;
			stretch_r  <= '0;
			cnt_r      <= '0;
			addr_act_r <= 1'b0;
			rd_stb_r   <= 1'b0;
			wr_stb_r   <= 1'b0;
		end
		else
		begin
			busy_r     <= busy_nxt;
			is_wr_r    <= wr_nxt;
			stretch_r  <= n_nxt;
			cnt_r      <= cnt_nxt;
			addr_act_r <= busy_nxt;
			rd_stb_r   <= busy_nxt && !wr_nxt;
			wr_stb_r   <= busy_nxt && wr_nxt && wr_win;
		end
	end

	assign addr_act = addr_act_r;
	assign rd_stb   = rd_stb_r;
	assign wr_stb   = wr_stb_r;
	assign busy     = busy_r;

	// helper run-length counters for the width checks
	logic [XCNT_W-1:0] arun_r;
	logic [XCNT_W-1:0] wrun_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arun_r <= '0;
			wrun_r <= '0;
		end
		else
		begin
			arun_r <= addr_act_r ? arun_r + 4'h1 : 4'h0;
			wrun_r <= wr_stb_r ? wrun_r + 4'h1 : 4'h0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_addr_width_len: assert property ($fell(addr_act_r) |->
		arun_r == {1'b0, stretch_r} + (is_wr_r ? WRITE_EXTRA : READ_EXTRA))
		else $error("address width wrong for stretch value");
	chk_wr_strobe_len: assert property ($fell(wr_stb_r) |->
		wrun_r == ((stretch_r == 3'h0) ? 4'h1 : {1'b0, stretch_r}))
		else $error("write strobe width wrong");
	chk_rd_with_addr: assert property (rd_stb_r |-> addr_act_r && !is_wr_r)
		else $error("read strobe outside address window");
	cov_write_stretch7: cover property (wr_stb_r && stretch_r == 3'h7);
	cov_read_stretch0: cover property ($fell(rd_stb_r) && stretch_r == 3'h0);
endmodule
`default_nettype wire

// *** verilog/ccs_core_regs.sv ***
// ccs_core_regs: core special function registers, port pins and movx timing.
// assumes an instruction sequencer on the same clock drives sfr and core strobes.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - status word carry, aux, user, overflow bits
// - status bits 4:3 pick register bank
// - status bit 0 tracks accumulator parity
// - stack pointer resets 07, pre-increments on push
// - two 16-bit data pointers, byte loadable
// - program counter resets zero, increments per fetch
// - port register: direction high, level low nibble
// - direction one means output, zero input
// - output level one high, zero low
// - port read returns real pin level
// - pins blocked until port enable bit set
// - stretch control low bits, default one
// - read address and strobe last n+1
// - write address n+2, strobe n, min one
// - accumulator operand, helper reg for mul/div
// - register set serves full instruction set
// - reset values: ports ff, stretch 01, sp 07, else 00
module ccs_core_regs
(
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire ccs_pkg::ccs_sfr_req_t   sfr_req,
	output logic [7:0]                   sfr_rdata,
	input  wire ccs_pkg::ccs_ioram_req_t ioram_req,
	input  wire ccs_pkg::ccs_core_req_t  core_req,
	input  wire ccs_pkg::ccs_xmem_req_t  xmem_req,
	output logic [7:0]                   accumulator,
	output logic [7:0]                   multiply_helper,
	output logic [7:0]                   program_status,
	output logic [7:0]                   bank_base,
	output logic [7:0]                   stack_pointer,
	output logic [15:0]                  data_pointer_zero,
	output logic [15:0]                  data_pointer_one,
	output logic [15:0]                  instr_pointer,
	input  wire logic [15:0]             multiplexed_pins_in,
	output logic [15:0]                  multiplexed_pins_out,
	output logic [15:0]                  multiplexed_pins_oe_n,
	output logic [15:0]                  mem_addr,
	output logic [7:0]                   mem_wdata,
	output logic                         mem_addr_act,
	output logic                         mem_rd,
	output logic                         mem_wr,
	output logic                         xmem_busy
);
	import ccs_pkg::*;

	logic        rst_s1_r;
	logic        rst_n_r;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	logic [7:0]  acc_r;
	logic [7:0]  helper_r;
	logic [7:0]  psw_r;
	logic        parity_r;
	logic [7:0]  bank_base_r;
	logic [7:0]  sp_r;
	logic [7:0]  dp0l_r;
	logic [7:0]  dp0h_r;
	logic [7:0]  dp1l_r;
	logic [7:0]  dp1h_r;
	logic [15:0] pc_r;
	logic [7:0]  stretch_r;
	logic        port_en_r;
	logic [7:0]  rdata_r;
	logic [15:0] pin_s1_r;
	logic [15:0] pin_s2_r;
	logic [15:0] pin_out_r;
	logic [15:0] pin_oe_n_r;
	logic [15:0] xaddr_r;
	logic [7:0]  xwdata_r;
	logic [7:0]  port_r [NUM_PORTS];

	wire        wr_acc     = sfr_req.wr && (sfr_req.addr == ADDR_ACC);
	wire        wr_helper  = sfr_req.wr && (sfr_req.addr == ADDR_HELPER);
	wire        wr_psw     = sfr_req.wr && (sfr_req.addr == ADDR_PSW);
	wire        wr_sp      = sfr_req.wr && (sfr_req.addr == ADDR_SP);
	wire        wr_dp0l    = sfr_req.wr && (sfr_req.addr == ADDR_DP0_LOW);
	wire        wr_dp0h    = sfr_req.wr && (sfr_req.addr == ADDR_DP0_HIGH);
	wire        wr_dp1l    = sfr_req.wr && (sfr_req.addr == ADDR_DP1_LOW);
	wire        wr_dp1h    = sfr_req.wr && (sfr_req.addr == ADDR_DP1_HIGH);
	wire        wr_stretch = sfr_req.wr && (sfr_req.addr == ADDR_STRETCH);
	wire        wr_port_en = ioram_req.wr && (ioram_req.addr == IORAM_PORT_EN_ADDR);

	// sequencer strobes win over a same-cycle sfr write to the same register, except push with pop together, where an sp write lands
	wire [7:0]  acc_nxt    = core_req.acc_we ? core_req.acc_wdata :
		(wr_acc ? sfr_req.wdata : acc_r);
	wire [7:0]  helper_nxt = core_req.helper_we ? core_req.helper_wdata :
		(wr_helper ? sfr_req.wdata : helper_r);
	wire [7:0]  psw_base   = wr_psw ? sfr_req.wdata : psw_r;
	wire [7:0]  psw_flags  = {core_req.carry, core_req.aux, psw_base[PSW_USER0],
		psw_base[PSW_BANK_HI:PSW_BANK_LO], core_req.over, psw_base[PSW_USER1:0]};
	wire [7:0]  psw_nxt    = core_req.flags_we ? psw_flags : psw_base;
	// parity stored beside the status byte, written bits are ignored
	wire        parity_nxt = ^acc_nxt;
	wire [7:0]  bank_nxt   = {3'h0, psw_nxt[PSW_BANK_HI:PSW_BANK_LO], 3'h0};
	wire [7:0]  sp_step    = core_req.push ? sp_r + 8'h01 :
		(core_req.pop ? sp_r - 8'h01 : sp_r);
	wire        sp_core    = core_req.push ^ core_req.pop;
	wire [7:0]  sp_nxt     = sp_core ? sp_step : (wr_sp ? sfr_req.wdata : sp_r);
	wire [15:0] pc_nxt     = core_req.pc_load ? core_req.pc_wdata :
		(core_req.pc_inc ? pc_r + 16'h0001 : pc_r);
	wire [7:0]  psw_view   = {psw_r[7:1], parity_r};

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			acc_r       <= RST_GEN;
			helper_r    <= RST_GEN;
			psw_r       <= RST_GEN;
			parity_r    <= 1'b0;
			bank_base_r <= RST_GEN;
			sp_r        <= RST_SP;
			pc_r        <= RST_PC;
			stretch_r   <= RST_STRETCH;
		end
		else
		begin
			acc_r       <= acc_nxt;
			helper_r    <= helper_nxt;
			psw_r       <= psw_nxt;
			parity_r    <= parity_nxt;
			bank_base_r <= bank_nxt;
			sp_r        <= sp_nxt;
			pc_r        <= pc_nxt;
			stretch_r   <= wr_stretch ? sfr_req.wdata : stretch_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			dp0l_r <= RST_GEN;
			dp0h_r <= RST_GEN;
			dp1l_r <= RST_GEN;
			dp1h_r <= RST_GEN;
		end
		else
		begin
			dp0l_r <= wr_dp0l ? sfr_req.wdata : dp0l_r;
			dp0h_r <= wr_dp0h ? sfr_req.wdata : dp0h_r;
			dp1l_r <= wr_dp1l ? sfr_req.wdata : dp1l_r;
			dp1h_r <= wr_dp1h ? sfr_req.wdata : dp1h_r;
		end
	end

	// port enable lives in io ram; holds pins quiet through power-up
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			port_en_r <= 1'b0;
		else if (wr_port_en)
			port_en_r <= ioram_req.wdata[PORT_EN_BIT];
	end

	// pins are asynchronous to clk
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end
		else
		begin
			pin_s1_r <= multiplexed_pins_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	localparam logic [7:0] PORT_ADDR [NUM_PORTS] = '{ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT3};
	wire [15:0] pin_direction_bits;
	wire [15:0] pin_level_bits;
	wire [7:0]  port_view [NUM_PORTS];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++)
		begin : g_port
			wire port_wr = sfr_req.wr && (sfr_req.addr == PORT_ADDR[gi]);
			always_ff @(posedge clk or negedge rst_n_r)
			begin
				if (!rst_n_r)
					port_r[gi] <= RST_PORT;
				else if (port_wr)
					port_r[gi] <= sfr_req.wdata;
			end
			assign pin_direction_bits[gi*4 +: 4] = port_r[gi][7:4];
			assign pin_level_bits[gi*4 +: 4]     = port_r[gi][3:0];
			// readback sees the pad, not the latch, even when driving
			assign port_view[gi] = {port_r[gi][7:4], pin_s2_r[gi*4 +: 4]};
		end
	endgenerate

	// oe_n low drives the pad
	wire [15:0] drive_en = pin_direction_bits & {NUM_PINS{port_en_r}};
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			pin_out_r  <= '0;
			pin_oe_n_r <= '1;
		end
		else
		begin
			pin_out_r  <= pin_level_bits;
			pin_oe_n_r <= ~drive_en;
		end
	end

	logic [7:0] rd_mux;
	always_comb
	begin
		unique case (sfr_req.addr)
			ADDR_PORT0:    rd_mux = port_view[0];
			ADDR_PORT1:    rd_mux = port_view[1];
			ADDR_PORT2:    rd_mux = port_view[2];
			ADDR_PORT3:    rd_mux = port_view[3];
			ADDR_SP:       rd_mux = sp_r;
			ADDR_DP0_LOW:  rd_mux = dp0l_r;
			ADDR_DP0_HIGH: rd_mux = dp0h_r;
			ADDR_DP1_LOW:  rd_mux = dp1l_r;
			ADDR_DP1_HIGH: rd_mux = dp1h_r;
			ADDR_STRETCH:  rd_mux = stretch_r;
			ADDR_PSW:      rd_mux = psw_view;
			ADDR_ACC:      rd_mux = acc_r;
			ADDR_HELPER:   rd_mux = helper_r;
			default:       rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			rdata_r <= 8'h00;
		else if (sfr_req.rd)
			rdata_r <= rd_mux;
	end

	// movx address/data held for the whole stretched access
	logic t_busy;
	wire  x_start = !t_busy && (xmem_req.rd || xmem_req.wr);
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			xaddr_r  <= '0;
			xwdata_r <= '0;
		end
		else if (x_start)
		begin
			xaddr_r  <= xmem_req.addr;
			xwdata_r <= xmem_req.wdata;
		end
	end

	ccs_stretch_timer u_stretch (
		.clk      (clk),
		.rst_n    (rst_n_r),
		.start_rd (xmem_req.rd && !xmem_req.wr),
		.start_wr (xmem_req.wr),
		.stretch  (stretch_r[STRETCH_W-1:0]),
		.addr_act (mem_addr_act),
		.rd_stb   (mem_rd),
		.wr_stb   (mem_wr),
		.busy     (t_busy)
	);

	assign sfr_rdata             = rdata_r;
	assign accumulator           = acc_r;
	assign multiply_helper       = helper_r;
	assign program_status        = psw_view;
	assign bank_base             = bank_base_r;
	assign stack_pointer         = sp_r;
	assign data_pointer_zero     = {dp0h_r, dp0l_r};
	assign data_pointer_one      = {dp1h_r, dp1l_r};
	assign instr_pointer         = pc_r;
	assign multiplexed_pins_out  = pin_out_r;
	assign multiplexed_pins_oe_n = pin_oe_n_r;
	assign mem_addr              = xaddr_r;
	assign mem_wdata             = xwdata_r;
	assign xmem_busy             = t_busy;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_r);

	chk_parity_tracks_acc: assert property (parity_r == ^acc_r)
		else $error("parity bit does not match accumulator");
	chk_push_pre_inc: assert property (core_req.push && !core_req.pop |=>
		sp_r == $past(sp_r) + 8'h01)
		else $error("stack pointer not incremented on push");
	chk_pc_fetch_step: assert property (core_req.pc_inc && !core_req.pc_load |=>
		pc_r == $past(pc_r) + 16'h0001)
		else $error("program counter not advanced");
	chk_bank_base_sel: assert property (bank_base_r == {3'h0, psw_r[4:3], 3'h0})
		else $error("bank base does not follow status bits");
	chk_port_block: assert property (!port_en_r |=> multiplexed_pins_oe_n == 16'hffff)
		else $error("pins driven while port enable clear");
	chk_dir_drive: assert property (##1 multiplexed_pins_oe_n ==
		~($past(pin_direction_bits) & {16{$past(port_en_r)}}))
		else $error("output enable does not follow direction bits");
	chk_port_readback: assert property (sfr_req.rd &&
		sfr_req.addr == ADDR_PORT1 |=>
		sfr_rdata == {$past(port_r[1][7:4]), $past(pin_s2_r[7:4])})
		else $error("port read does not show pin level");
	chk_acc_core_write: assert property (core_req.acc_we |=>
		accumulator == $past(core_req.acc_wdata))
		else $error("accumulator not loaded");
	chk_flag_update: assert property (core_req.flags_we |=>
		psw_r[7] == $past(core_req.carry) && psw_r[6] == $past(core_req.aux)
		&& psw_r[2] == $past(core_req.over))
		else $error("status flags not updated");
	cov_push: cover property (core_req.push ##1 core_req.push);
	cov_pin_drive: cover property (port_en_r && multiplexed_pins_oe_n != 16'hffff);
	cov_bank3: cover property (bank_base_r == 8'h18);
endmodule
`default_nettype wire

// *** verif/ccs_xmem_model.sv ***
// ccs_xmem_model: far side of the block, extended-memory latch and board pins.
// assumes mem strobes and pin enables come from the block on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ccs_xmem_model
(
	input  wire logic        clk,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_addr_act,
	input  wire logic        mem_wr,
	input  wire logic [15:0] pins_out,
	input  wire logic [15:0] pins_oe_n,
	input  wire logic [15:0] pins_ext,
	output logic [15:0]      pins_in,
	output logic [15:0]      last_addr,
	output logic [7:0]       last_data
);
	// pad follows the driver where enabled, the board level elsewhere
	assign pins_in = (pins_out & ~pins_oe_n) | (pins_ext & pins_oe_n);
	always_ff @(posedge clk)
	begin
		if (mem_wr && mem_addr_act)
		begin
			last_addr <= mem_addr;
			last_data <= mem_wdata;
		end
	end
endmodule
`default_nettype wire

// *** verif/cpu_core_sfr_and_port_regs_test.sv ***
// cpu_core_sfr_and_port_regs_test: self-checking bench for ccs_core_regs.
// assumes ccs_pkg and the far-side model ccs_xmem_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module cpu_core_sfr_and_port_regs_test;
	import ccs_pkg::*;
	localparam logic [15:0] EXT_LEVEL = 16'h3c96;
	localparam logic [7:0]  RA [10] = '{ADDR_ACC, ADDR_HELPER, ADDR_PSW, ADDR_SP,
		ADDR_DP0_LOW, ADDR_DP0_HIGH, ADDR_DP1_LOW, ADDR_DP1_HIGH, ADDR_STRETCH, 8'h87};
	localparam logic [7:0]  RE [10] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h01, 8'h00};
	localparam logic [7:0]  PA [4] = '{ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT3};
	localparam logic [7:0]  PV [4] = '{8'hf5, 8'h93, 8'h6a, 8'h0c};
	logic           clk;
	logic           reset_n;
	ccs_sfr_req_t   sfr_req;
	ccs_ioram_req_t ioram_req;
	ccs_core_req_t  core_req;
	ccs_xmem_req_t  xmem_req;
	logic [7:0]     sfr_rdata, accumulator, multiply_helper, program_status, bank_base;
	logic [7:0]     stack_pointer, mem_wdata, last_data;
	logic [15:0]    data_pointer_zero, data_pointer_one, instr_pointer, mem_addr;
	logic [15:0]    pins_in, pins_out, pins_oe_n, last_addr;
	logic           mem_addr_act, mem_rd, mem_wr, xmem_busy;
	int             bad_count, n_compared;

	ccs_core_regs u_ccs_core_regs (.clk(clk), .reset_n(reset_n), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .ioram_req(ioram_req), .core_req(core_req),
		.xmem_req(xmem_req), .accumulator(accumulator), .multiply_helper(multiply_helper),
		.program_status(program_status), .bank_base(bank_base),
		.stack_pointer(stack_pointer), .data_pointer_zero(data_pointer_zero),
		.data_pointer_one(data_pointer_one), .instr_pointer(instr_pointer),
		.multiplexed_pins_in(pins_in), .multiplexed_pins_out(pins_out),
		.multiplexed_pins_oe_n(pins_oe_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_addr_act(mem_addr_act), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.xmem_busy(xmem_busy));
	ccs_xmem_model u_ccs_xmem_model (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_addr_act(mem_addr_act), .mem_wr(mem_wr), .pins_out(pins_out),
		.pins_oe_n(pins_oe_n), .pins_ext(EXT_LEVEL), .pins_in(pins_in),
		.last_addr(last_addr), .last_data(last_data));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) sfr_req <= '{a, 1'b1, 1'b0, d};
		@(posedge clk) sfr_req <= '0;
		#1;
	endtask

	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge clk) sfr_req <= '0;
		#1 d = sfr_rdata;
	endtask

	task automatic core(input ccs_core_req_t c);
		@(posedge clk) core_req <= c;
		@(posedge clk) core_req <= '0;
		#1;
	endtask

	task automatic port_en(input logic [7:0] d);
		@(posedge clk) ioram_req <= '{IORAM_PORT_EN_ADDR, 1'b1, d};
		@(posedge clk) ioram_req <= '0;
	endtask

	task automatic t_reset();
		logic [7:0] d;
		for (int i = 0; i < 10; i++)
		begin
			sfr_rd(RA[i], d);
			check("reset byte", {8'h00, RE[i]}, {8'h00, d});
		end
		check("pc reset", 16'h0000, instr_pointer);
		check("oe_n reset", 16'hffff, pins_oe_n);
		for (int k = 0; k < 4; k++)
		begin
			sfr_rd(PA[k], d);
			check("port reset", {8'h00, 4'hf, EXT_LEVEL[4*k+:4]}, {8'h00, d});
		end
	endtask

	task automatic t_pc();
		ccs_core_req_t c;
		c = '0;
		c.pc_inc = 1'b1;
		repeat (3) core(c);
		check("pc inc", 16'h0003, instr_pointer);
		c.pc_load = 1'b1;
		c.pc_wdata = 16'hffff;
		core(c);
		check("pc load", 16'hffff, instr_pointer);
		c.pc_load = 1'b0;
		core(c);
		check("pc wrap", 16'h0000, instr_pointer);
	endtask

	task automatic t_stack();
		ccs_core_req_t c;
		c = '0;
		c.push = 1'b1;
		core(c);
		check("sp push", 16'h0008, {8'h00, stack_pointer});
		c.pop = 1'b1;
		core(c);
		check("sp push pop", 16'h0008, {8'h00, stack_pointer});
		c.push = 1'b0;
		core(c);
		check("sp pop", 16'h0007, {8'h00, stack_pointer});
		sfr_wr(ADDR_SP, 8'hff);
		c = '0;
		c.push = 1'b1;
		core(c);
		check("sp wrap", 16'h0000, {8'h00, stack_pointer});
	endtask

	task automatic t_psw();
		logic [7:0]    v [4] = '{8'h00, 8'h01, 8'hff, 8'h7f};
		logic [7:0]    d;
		ccs_core_req_t c;
		for (int i = 0; i < 4; i++)
		begin
			sfr_wr(ADDR_ACC, v[i]);
			check("parity", {15'h0, ^v[i]}, {8'h00, program_status} & 16'h0001);
		end
		sfr_wr(ADDR_PSW, 8'h00);
		check("psw bit0 ro", 16'h0001, {8'h00, program_status});
		sfr_wr(ADDR_PSW, 8'h22);
		sfr_rd(ADDR_PSW, d);
		check("psw user", 16'h0023, {8'h00, d});
		for (int b = 0; b < 4; b++)
		begin
			sfr_wr(ADDR_PSW, {3'b000, b[1:0], 3'b000});
			check("bank base", {8'h00, 3'b000, b[1:0], 3'b000}, {8'h00, bank_base});
		end
		sfr_wr(ADDR_PSW, 8'h00);
		c = '0;
		c.flags_we = 1'b1;
		c.carry = 1'b1;
		c.aux = 1'b1;
		c.over = 1'b1;
		core(c);
		check("psw flags", 16'h00c5, {8'h00, program_status});
		c = '0;
		c.acc_we = 1'b1;
		c.acc_wdata = 8'h03;
		c.helper_we = 1'b1;
		c.helper_wdata = 8'h5a;
		core(c);
		check("acc core", 16'h0003, {8'h00, accumulator});
		check("acc parity", 16'h00c4, {8'h00, program_status});
		check("helper out", 16'h005a, {8'h00, multiply_helper});
		sfr_rd(ADDR_HELPER, d);
		check("helper", 16'h005a, {8'h00, d});
	endtask

	task automatic t_data_pointer_zero();
		logic [7:0] d;
		sfr_wr(ADDR_DP0_LOW, 8'h11);
		sfr_wr(ADDR_DP0_HIGH, 8'h22);
		sfr_wr(ADDR_DP1_LOW, 8'h33);
		sfr_wr(ADDR_DP1_HIGH, 8'h44);
		check("dptr0", 16'h2211, data_pointer_zero);
		check("dptr1", 16'h4433, data_pointer_one);
		sfr_rd(ADDR_DP1_HIGH, d);
		check("dptr1 high", 16'h0044, {8'h00, d});
	endtask

	task automatic t_ports();
		logic [7:0] d;
		logic [3:0] dir;
		logic [3:0] lvl;
		sfr_wr(ADDR_PORT0, 8'hf5);
		repeat (3) @(posedge clk);
		#1 check("oe blocked", 16'hffff, pins_oe_n);
		port_en(8'h20);
		for (int k = 0; k < 4; k++)
		begin
			dir = PV[k][7:4];
			sfr_wr(PA[k], PV[k]);
			repeat (4) @(posedge clk);
			#1 check("oe nibble", {12'h0, ~dir}, {12'h0, pins_oe_n[4*k+:4]});
			check("out nibble", {12'h0, PV[k][3:0]}, {12'h0, pins_out[4*k+:4]});
			sfr_rd(PA[k], d);
			lvl = (PV[k][3:0] & dir) | (EXT_LEVEL[4*k+:4] & ~dir);
			check("port read", {8'h00, dir, lvl}, {8'h00, d});
		end
		port_en(8'h00);
		repeat (3) @(posedge clk);
		#1 check("oe reblocked", 16'hffff, pins_oe_n);
	endtask

	task automatic xfer(input logic wr, input int n);
		int          ca, cr, cw;
		logic [15:0] a;
		logic [7:0]  w;
		a = {8'h40, 5'h00, n[2:0]};
		w = 8'(n) ^ 8'h5a;
		ca = 0;
		cr = 0;
		cw = 0;
		@(posedge clk) xmem_req <= '{~wr, wr, a, w};
		// request still up while busy: must be ignored, address must not move
		@(posedge clk) xmem_req.addr <= a ^ 16'h0100;
		repeat (12)
		begin
			#1;
			if (mem_addr_act === 1'b1)
				ca++;
			if (mem_rd === 1'b1)
				cr++;
			if (mem_wr === 1'b1)
				cw++;
			@(posedge clk) xmem_req <= '0;
		end
		check("addr width", 16'(wr ? n + 2 : n + 1), 16'(ca));
		check("rd width", 16'(wr ? 0 : n + 1), 16'(cr));
		check("wr width", 16'(wr ? (n < 2 ? 1 : n) : 0), 16'(cw));
		check("busy end", 16'h0000, {15'h0, xmem_busy});
		check("mem addr", a, mem_addr);
		if (wr)
			check("mem data", {a[7:0], w}, {last_addr[7:0], last_data});
	endtask

	task automatic t_xmem();
		logic [7:0] d;
		for (int n = 0; n < 8; n++)
		begin
			sfr_wr(ADDR_STRETCH, 8'(n));
			sfr_rd(ADDR_STRETCH, d);
			check("stretch", 16'(n), {8'h00, d});
			xfer(1'b0, n);
			xfer(1'b1, n);
		end
	endtask

	initial
	begin
		#500us;
		bad_count++;
		tally_and_finish();
	end

	initial
	begin
		bad_count = 0;
		n_compared = 0;
		reset_n = 1'b0;
		sfr_req = '0;
		ioram_req = '0;
		core_req = '0;
		xmem_req = '0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_pc();
		t_stack();
		t_psw();
		t_data_pointer_zero();
		t_ports();
		t_xmem();
		tally_and_finish();
	end
endmodule
`default_nettype wire
